/* File: logic/ttc_pkg.sv */
// Package with constants and types of the trend trigger capture engine
package ttc_pkg;
   localparam int CHANNELS = 16;
   localparam int DEPTH = 100;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 7;
   localparam int CLK_MHZ = 125;
   localparam int TICK_US = 1000;
   localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
   localparam int RATE_MAX_MS = 20000;
   localparam int POST_MAX_PCT = 100;
   localparam logic [15:0] FLAG_FAULT = 16'h0008;
   localparam logic [15:0] FLAG_ALARM = 16'h0010;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_RATE = 8'h04;
   localparam logic [7:0] OFS_POST = 8'h08;
   localparam logic [7:0] OFS_DATA = 8'h0c;
   localparam logic [7:0] OFS_STAT = 8'h10;
   localparam logic [7:0] OFS_RDADDR = 8'h14;
   localparam logic [7:0] OFS_RDDATA = 8'h18;
   localparam logic [7:0] OFS_ACCESS = 8'h1c;
   localparam int CTRL_REARM = 0;
   localparam int CTRL_CONT = 1;
   localparam int CTRL_COND = 4;
   localparam int CTRL_ENA = 16;
   localparam logic [2:0] ACC_BASIC = 3'h1;
   typedef enum logic [2:0] {
      COND_EQ, COND_NE, COND_GT, COND_LT,
      COND_OR, COND_NOR, COND_AND, COND_NAND
   } ttc_cond_t;
   typedef enum {ST_STOP, ST_PRE, ST_POST} ttc_state_t;
endpackage : ttc_pkg

/* File: logic/ttc_mem.sv */
// Sample memory with registered read data
`timescale 1ns/10ps
module ttc_mem #(
   parameter int WIDTH = 256,
   parameter int DEPTH = 100,
   parameter int AW = 7
) (
   // Clock
   input wire logic clk,
   // Write side
   input wire logic wrEn,
   input wire logic [AW-1:0] wrAddr,
   input wire logic [WIDTH-1:0] wrData,
   // Read side
   input wire logic [AW-1:0] rdAddr,
   output logic [WIDTH-1:0] rdData
);
   logic [WIDTH-1:0] mem [DEPTH];
   always_ff @(posedge clk)
   begin
      if (wrEn)
      begin
         mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
   end
endmodule : ttc_mem

/* File: logic/ttc_top.sv */
// Trend trigger capture engine with Avalon-MM register slave
// What this block does
// - Up to sixteen channels, each sampling one assigned drive variable.
// - Each channel buffer holds exactly one hundred samples per trend.
// - Channel one value is the trigger operand; others are only recorded.
// - Unassigned channels are inactive; capture runs with fewer channels.
// - Sample interval accepts zero to twenty thousand milliseconds.
// - Interval zero means one sample every millisecond.
// - Post percentage sets share of buffer filled after trigger.
// - Single-shot triggers once, stops, waits for capture_rearm.
// - Capture_rearm clears stored samples of previous trend first.
// - Continuous mode re-arms itself until a readout stops it.
// - Conditions equal, not equal, greater, less against data value.
// - Boolean OR, NOR, AND, NAND against data value.
// - Trigger fires only when selected condition is true.
// - Condition selector starts at equal after reset.
// - Running while armed awaiting trigger or collecting post-trigger samples, else stopped, also during the capture_rearm clearing pass.
// - Configuration changes accepted only at basic access or higher.
`timescale 1ns/10ps
module ttc_top #(
   parameter int TICK = ttc_pkg::TICK_CYCLES,
   parameter int W = ttc_pkg::DATA_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Drive variables, channel k in bits k*W+W-1 : k*W
   input wire logic [ttc_pkg::CHANNELS*W-1:0] driveVars,
   // Avalon-MM slave
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Status
   output logic running
);
   localparam int CH = ttc_pkg::CHANNELS;
   localparam int AW = ttc_pkg::ADDR_W;
   localparam int MW = CH * W;
   localparam logic [AW-1:0] LAST = AW'(ttc_pkg::DEPTH - 1);

   // Synchronised drive variables, come from another domain
   logic [MW-1:0] varMeta_reg;
   logic [MW-1:0] varSync_reg;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         varMeta_reg <= '0;
         varSync_reg <= '0;
      end
      else
      begin
         varMeta_reg <= driveVars;
         varSync_reg <= varMeta_reg;
      end
   end

   // Configuration and engine state
   logic contMode_reg, contMode_next;
   ttc_pkg::ttc_cond_t cond_reg, cond_next;
   logic [15:0] chanEna_reg, chanEna_next;
   logic [14:0] rate_reg, rate_next;
   logic [6:0] post_reg, post_next;
   logic [W-1:0] trigData_reg, trigData_next;
   logic [2:0] access_reg, access_next;
   logic [AW-1:0] rdAddr_reg, rdAddr_next;
   ttc_pkg::ttc_state_t state_reg, state_next;
   logic [16:0] tick_reg, tick_next;
   logic [14:0] msCnt_reg, msCnt_next;
   logic [AW-1:0] wrPtr_reg, wrPtr_next;
   logic [AW-1:0] postLeft_reg, postLeft_next;
   logic [AW-1:0] trigPos_reg, trigPos_next;
   logic [AW-1:0] clrPtr_reg, clrPtr_next;
   logic clearing_reg, clearing_next;
   logic [1:0] busPh_reg, busPh_next;
   logic [31:0] readdata_next;
   logic running_next;
   logic waitrequest_next;

   logic memWr;
   logic [AW-1:0] memWrAddr;
   logic [MW-1:0] memWrData;
   logic [MW-1:0] memRdData;
   logic [MW-1:0] sampleMasked;
   logic [W-1:0] ch1;
   logic hit;
   logic sampleNow;
   logic allowCfg;
   logic [AW-1:0] postCount;
   logic [13:0] postProd;

   // Inactive channels record zero
   genvar g;
   generate
      for (g = 0; g < CH; g++)
      begin : gMask
         assign sampleMasked[g*W +: W] =
            chanEna_reg[g] ? varSync_reg[g*W +: W] : '0;
      end
   endgenerate

   ttc_mem #(.WIDTH(MW), .DEPTH(ttc_pkg::DEPTH), .AW(AW)) uMem (
      .clk(clk),
      .wrEn(memWr),
      .wrAddr(memWrAddr),
      .wrData(memWrData),
      .rdAddr(rdAddr_reg),
      .rdData(memRdData)
   );

   always_comb
   begin
      ch1 = sampleMasked[W-1:0];
      case (cond_reg)
         ttc_pkg::COND_EQ: hit = ch1 == trigData_reg;
         ttc_pkg::COND_NE: hit = ch1 != trigData_reg;
         ttc_pkg::COND_GT: hit = ch1 > trigData_reg;
         ttc_pkg::COND_LT: hit = ch1 < trigData_reg;
         ttc_pkg::COND_OR: hit = |(ch1 | trigData_reg);
         ttc_pkg::COND_NOR: hit = ~|(ch1 | trigData_reg);
         ttc_pkg::COND_AND: hit = |(ch1 & trigData_reg);
         default: hit = ~|(ch1 & trigData_reg);
      endcase
   end

   // Rounds down: 100 samples times percent over 100 is just the percent
   assign postProd = 14'(post_reg) * 14'(ttc_pkg::DEPTH);
   assign postCount = AW'(postProd / 14'(ttc_pkg::POST_MAX_PCT));
   assign allowCfg = access_reg >= ttc_pkg::ACC_BASIC;
   assign sampleNow = tick_reg == 17'(TICK - 1) &&
                      msCnt_reg >= rate_reg;

   always_comb
   begin
      contMode_next = contMode_reg;
      cond_next = cond_reg;
      chanEna_next = chanEna_reg;
      rate_next = rate_reg;
      post_next = post_reg;
      trigData_next = trigData_reg;
      access_next = access_reg;
      rdAddr_next = rdAddr_reg;
      state_next = state_reg;
      tick_next = tick_reg + 17'h00001;
      msCnt_next = msCnt_reg;
      wrPtr_next = wrPtr_reg;
      postLeft_next = postLeft_reg;
      trigPos_next = trigPos_reg;
      clrPtr_next = clrPtr_reg;
      clearing_next = clearing_reg;
      busPh_next = 2'h0;
      readdata_next = readdata;
      memWr = 1'b0;
      memWrAddr = wrPtr_reg;
      memWrData = sampleMasked;
      // Millisecond base; rate 0 and 1 both give one per millisecond
      if (tick_reg == 17'(TICK - 1))
      begin
         tick_next = '0;
         msCnt_next = sampleNow ? 15'h0001 : msCnt_reg + 15'h0001;
      end
      // Clearing pass walks the whole buffer before capture resumes
      if (clearing_reg)
      begin
         memWr = 1'b1;
         memWrAddr = clrPtr_reg;
         memWrData = '0;
         clrPtr_next = clrPtr_reg + 7'h01;
         if (clrPtr_reg == LAST)
         begin
            clearing_next = 1'b0;
            clrPtr_next = '0;
            state_next = ttc_pkg::ST_PRE;
            wrPtr_next = '0;
         end
      end
      else if (sampleNow && state_reg != ttc_pkg::ST_STOP)
      begin
         memWr = 1'b1;
         wrPtr_next = (wrPtr_reg == LAST) ? '0 : wrPtr_reg + 7'h01;
         if (state_reg == ttc_pkg::ST_PRE && hit)
         begin
            trigPos_next = wrPtr_reg;
            postLeft_next = postCount;
            state_next = (postCount == '0) ? ttc_pkg::ST_STOP :
                         ttc_pkg::ST_POST;
         end
         else if (state_reg == ttc_pkg::ST_POST)
         begin
            postLeft_next = postLeft_reg - 7'h01;
            if (postLeft_reg == 7'h01)
            begin
               state_next = ttc_pkg::ST_STOP;
            end
         end
      end
      // Bus slave, answer two cycles after request
      if ((read || write) && busPh_reg == 2'h0)
      begin
         busPh_next = 2'h1;
      end
      else if (busPh_reg == 2'h1)
      begin
         busPh_next = 2'h2;
         if (write)
         begin
            if (address == ttc_pkg::OFS_ACCESS)
            begin
               access_next = writedata[2:0];
            end
            else if (address == ttc_pkg::OFS_RDADDR)
            begin
               rdAddr_next = writedata[AW-1:0];
            end
            else if (address == ttc_pkg::OFS_CTRL && allowCfg)
            begin
               contMode_next = writedata[ttc_pkg::CTRL_CONT];
               chanEna_next = writedata[ttc_pkg::CTRL_ENA +: 16];
               cond_next = ttc_pkg::ttc_cond_t'(
                  writedata[ttc_pkg::CTRL_COND +: 3]);
               if (writedata[ttc_pkg::CTRL_REARM])
               begin
                  clearing_next = 1'b1;
                  clrPtr_next = '0;
                  state_next = ttc_pkg::ST_STOP;
               end
            end
            else if (address == ttc_pkg::OFS_RATE && allowCfg)
            begin
               rate_next = (writedata > 32'(ttc_pkg::RATE_MAX_MS))
                  ? 15'(ttc_pkg::RATE_MAX_MS) : writedata[14:0];
            end
            else if (address == ttc_pkg::OFS_POST && allowCfg)
            begin
               post_next = (writedata > 32'(ttc_pkg::POST_MAX_PCT))
                  ? 7'(ttc_pkg::POST_MAX_PCT) : writedata[6:0];
            end
            else if (address == ttc_pkg::OFS_DATA && allowCfg)
            begin
               trigData_next = writedata[W-1:0];
            end
         end
         else
         begin
            readdata_next = 32'h00000000;
            if (address == ttc_pkg::OFS_CTRL)
            begin
               readdata_next = {chanEna_reg, 9'h000, 3'(cond_reg),
                                2'h0, contMode_reg, 1'b0};
            end
            else if (address == ttc_pkg::OFS_RATE)
            begin
               readdata_next = 32'(rate_reg);
            end
            else if (address == ttc_pkg::OFS_POST)
            begin
               readdata_next = 32'(post_reg);
            end
            else if (address == ttc_pkg::OFS_DATA)
            begin
               readdata_next = 32'(trigData_reg);
            end
            else if (address == ttc_pkg::OFS_STAT)
            begin
               readdata_next = {9'h000, trigPos_reg, 7'h00, wrPtr_reg,
                                clearing_reg, running};
            end
            else if (address == ttc_pkg::OFS_RDADDR)
            begin
               readdata_next = 32'(rdAddr_reg);
            end
            else if (address == ttc_pkg::OFS_ACCESS)
            begin
               readdata_next = 32'(access_reg);
            end
            else if (address >= ttc_pkg::OFS_RDDATA + 8'h08 &&
                     address < ttc_pkg::OFS_RDDATA + 8'h48)
            begin
               readdata_next = 32'(memRdData[(address[5:2] - 4'h8) * W
                                              +: W]);
            end
            else if (address == ttc_pkg::OFS_RDDATA)
            begin
               readdata_next = 32'(memRdData[W-1:0]);
               // Readout of a completed trend ends continuous capture
               if (contMode_reg && state_reg == ttc_pkg::ST_STOP)
               begin
                  contMode_next = 1'b0;
                  // Auto capture_rearm pending too, or capture would resume
                  clearing_next = 1'b0;
                  clrPtr_next = '0;
               end
            end
         end
      end
      // Continuous mode re-arms once the post count is done
      if (contMode_next && state_reg == ttc_pkg::ST_POST &&
          state_next == ttc_pkg::ST_STOP && !clearing_next)
      begin
         clearing_next = 1'b1;
         clrPtr_next = '0;
      end
      if (contMode_reg && state_reg == ttc_pkg::ST_PRE &&
          state_next == ttc_pkg::ST_STOP && !clearing_next &&
          contMode_next)
      begin
         clearing_next = 1'b1;
         clrPtr_next = '0;
      end
      running_next = state_next != ttc_pkg::ST_STOP;
      // Registered, low only in the answer cycle
      waitrequest_next = busPh_next != 2'h2;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         contMode_reg <= 1'b0;
         cond_reg <= ttc_pkg::COND_EQ;
         chanEna_reg <= '0;
         rate_reg <= '0;
         post_reg <= '0;
         trigData_reg <= '0;
         access_reg <= '0;
         rdAddr_reg <= '0;
         state_reg <= ttc_pkg::ST_STOP;
         tick_reg <= '0;
         msCnt_reg <= '0;
         wrPtr_reg <= '0;
         postLeft_reg <= '0;
         trigPos_reg <= '0;
         clrPtr_reg <= '0;
         clearing_reg <= 1'b0;
         busPh_reg <= 2'h0;
         readdata <= '0;
         running <= 1'b0;
         waitrequest <= 1'b1;
      end
      else
      begin
         contMode_reg <= contMode_next;
         cond_reg <= cond_next;
         chanEna_reg <= chanEna_next;
         rate_reg <= rate_next;
         post_reg <= post_next;
         trigData_reg <= trigData_next;
         access_reg <= access_next;
         rdAddr_reg <= rdAddr_next;
         state_reg <= state_next;
         tick_reg <= tick_next;
         msCnt_reg <= msCnt_next;
         wrPtr_reg <= wrPtr_next;
         postLeft_reg <= postLeft_next;
         trigPos_reg <= trigPos_next;
         clrPtr_reg <= clrPtr_next;
         clearing_reg <= clearing_next;
         busPh_reg <= busPh_next;
         readdata <= readdata_next;
         running <= running_next;
         waitrequest <= waitrequest_next;
      end
   end

   sequence trigSeq;
      sampleNow && !clearing_reg && state_reg == ttc_pkg::ST_PRE && hit;
   endsequence

   trig_stops_pre_a: assert property (@(posedge clk) disable iff (rst)
      trigSeq |=> state_reg != ttc_pkg::ST_PRE)
      else $error("trigger did not leave pre state");
   no_trig_a: assert property (@(posedge clk) disable iff (rst)
      sampleNow && !clearing_reg && state_reg == ttc_pkg::ST_PRE && !hit
      && busPh_reg != 2'h1 |=> state_reg == ttc_pkg::ST_PRE)
      else $error("trigger fired without condition");
   run_status_a: assert property (@(posedge clk) disable iff (rst)
      running == (state_reg != ttc_pkg::ST_STOP))
      else $error("running flag disagrees with state");
   post_bound_a: assert property (@(posedge clk) disable iff (rst)
      state_reg == ttc_pkg::ST_POST |-> postLeft_reg <= 7'd100)
      else $error("post count out of range");
   rate_bound_a: assert property (@(posedge clk) disable iff (rst)
      rate_reg <= 15'd20000)
      else $error("rate above limit");
   post_pct_a: assert property (@(posedge clk) disable iff (rst)
      post_reg <= 7'd100)
      else $error("post percent above limit");
   access_gate_a: assert property (@(posedge clk) disable iff (rst)
      access_reg < ttc_pkg::ACC_BASIC |=> $stable(rate_reg))
      else $error("config changed at low access");
   clear_done_a: assert property (@(posedge clk) disable iff (rst)
      $rose(clearing_reg) |-> ##100 !clearing_reg)
      else $error("clear pass length wrong");
   wr_ptr_a: assert property (@(posedge clk) disable iff (rst)
      wrPtr_reg <= LAST)
      else $error("write pointer past buffer");
   single_hold_a: assert property (@(posedge clk) disable iff (rst)
      !contMode_reg && state_reg == ttc_pkg::ST_STOP && !clearing_reg
      && !(write && busPh_reg == 2'h1) |=> state_reg == ttc_pkg::ST_STOP)
      else $error("single shot restarted without capture_rearm");
endmodule : ttc_top

/* File: test/ttc_drive_model.sv */
// Drive variable source facing the capture engine
`timescale 1ns/10ps
module ttc_drive_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Channel one value chosen by the bench
   input wire logic [15:0] trigVal,
   // Drive variables toward the engine
   output logic [ttc_pkg::CHANNELS*ttc_pkg::DATA_W-1:0] driveVars
);
   logic [15:0] spin_reg;
   // Others churn every cycle so a wrong channel select shows up
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         spin_reg <= 16'h0000;
      end
      else
      begin
         spin_reg <= spin_reg + 16'h0101;
      end
   end
   assign driveVars = {{15{spin_reg}}, trigVal};
endmodule : ttc_drive_model

/* File: test/ttc_top_bench.sv */
// Self-checking bench for the trend trigger capture engine
`timescale 1ns/10ps
module ttc_top_bench;
   localparam int TICK = 10;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] address = 8'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h00000000;
   logic [31:0] readdata;
   logic waitrequest;
   logic running;
   logic [15:0] trigVal = 16'h0001;
   logic [255:0] driveVars;
   logic [31:0] rd;
   int miscompares = 0;
   int checks_done = 0;
   int cyc;
   int trig;
   // Per condition: first a case that fires, then one that does not
   logic [15:0] tData [16] = '{16'h0018, 16'h0018, 16'h0018, 16'h0018,
      16'h0018, 16'h0018, 16'h0018, 16'h0018, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0018, 16'h0018, 16'h0018, 16'h0018};
   logic [15:0] tVal [16] = '{16'h0018, 16'h0019, 16'h0019, 16'h0018,
      16'h0019, 16'h0018, 16'h0017, 16'h0018, 16'h0001, 16'h0000,
      16'h0000, 16'h0001, ttc_pkg::FLAG_FAULT, 16'h0007, 16'h0007,
      ttc_pkg::FLAG_ALARM};

   always #4 clk = ~clk;

   ttc_drive_model src (
      .clk(clk),
      .rst(rst),
      .trigVal(trigVal),
      .driveVars(driveVars)
   );

   ttc_top #(.TICK(TICK)) dut (
      .clk(clk),
      .rst(rst),
      .driveVars(driveVars),
      .address(address),
      .read(read),
      .write(write),
      .writedata(writedata),
      .readdata(readdata),
      .waitrequest(waitrequest),
      .running(running)
   );

   task stop_test;
      if (miscompares == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : stop_test

   task check_word(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         miscompares++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : check_word

   task check_flag(input logic got, input logic exp);
      checks_done++;
      if (got !== exp)
      begin
         miscompares++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : check_flag

   // Request held until the edge that samples waitrequest low
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      address <= a;
      writedata <= d;
      write <= wr;
      read <= ~wr;
      @(posedge clk);
      while (waitrequest !== 1'b0)
      begin
         n++;
         if (n > 20)
         begin
            miscompares++;
            stop_test();
         end
         @(posedge clk);
      end
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
   endtask : bus

   task wait_run(input logic lvl, input int lim);
      cyc = 0;
      @(negedge clk);
      while (running !== lvl)
      begin
         cyc++;
         if (cyc > lim)
         begin
            miscompares++;
            stop_test();
         end
         @(negedge clk);
      end
      @(posedge clk);
   endtask : wait_run

   task check_run(input logic exp);
      @(negedge clk);
      check_flag(running, exp);
      @(posedge clk);
   endtask : check_run

   // Only channel one enabled, the rest stay inactive
   task arm(input logic cont, input logic [2:0] cond, input logic [15:0] d);
      bus(1'b1, ttc_pkg::OFS_DATA, {16'h0000, d});
      bus(1'b1, ttc_pkg::OFS_CTRL, {16'h0001, 9'h000, cond, 2'b00, cont, 1'b1});
      wait_run(1'b1, 400);
   endtask : arm

   task sample(input int idx, input logic [15:0] exp);
      bus(1'b1, ttc_pkg::OFS_RDADDR, 32'(idx));
      bus(1'b0, ttc_pkg::OFS_RDDATA, 32'h00000000);
      check_word(rd, {16'h0000, exp});
   endtask : sample

   initial
   begin
      repeat (60000) @(posedge clk);
      miscompares++;
      stop_test();
   end

   initial
   begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check_run(1'b0);
      bus(1'b0, ttc_pkg::OFS_CTRL, 32'h00000000);
      check_word(rd & 32'h00000070, 32'h00000000);
      // No access level yet: config and capture_rearm must be ignored
      bus(1'b1, ttc_pkg::OFS_CTRL, 32'h00010053);
      bus(1'b0, ttc_pkg::OFS_CTRL, 32'h00000000);
      check_word(rd, 32'h00000000);
      repeat (200) @(posedge clk);
      check_run(1'b0);
      bus(1'b1, ttc_pkg::OFS_ACCESS, {29'h0, ttc_pkg::ACC_BASIC});
      bus(1'b1, ttc_pkg::OFS_RATE, 32'd30000);
      bus(1'b0, ttc_pkg::OFS_RATE, 32'h00000000);
      check_word(rd, 32'(ttc_pkg::RATE_MAX_MS));
      bus(1'b1, ttc_pkg::OFS_POST, 32'd150);
      bus(1'b0, ttc_pkg::OFS_POST, 32'h00000000);
      check_word(rd, 32'(ttc_pkg::POST_MAX_PCT));
      bus(1'b1, ttc_pkg::OFS_RATE, 32'h00000000);
      bus(1'b1, ttc_pkg::OFS_POST, 32'd10);
      // Single shot, let the pre-trigger ring wrap before firing
      arm(1'b0, ttc_pkg::COND_EQ, 16'h0018);
      repeat (1200) @(posedge clk);
      check_run(1'b1);
      trigVal <= 16'h0018;
      wait_run(1'b0, 200);
      check_flag(cyc >= 100 && cyc <= 125, 1'b1);
      trigVal <= 16'h0001;
      repeat (300) @(posedge clk);
      check_run(1'b0);
      bus(1'b0, ttc_pkg::OFS_STAT, 32'h00000000);
      trig = int'(rd[22:16]);
      sample(trig, 16'h0018);
      sample((trig + 10) % 100, 16'h0018);
      sample((trig + 11) % 100, 16'h0001);
      sample((trig + 99) % 100, 16'h0001);
      // Re-arm clears the stored trend, so old sample slots read back zero
      trigVal <= 16'h0000;
      bus(1'b1, ttc_pkg::OFS_RATE, 32'd200);
      arm(1'b0, ttc_pkg::COND_EQ, 16'h0018);
      sample(trig, 16'h0000);
      sample((trig + 11) % 100, 16'h0000);
      bus(1'b1, ttc_pkg::OFS_RATE, 32'd1);
      bus(1'b1, ttc_pkg::OFS_POST, 32'h00000000);
      for (int i = 0; i < 16; i++)
      begin
         trigVal <= tVal[i];
         arm(1'b0, 3'(i / 2), tData[i]);
         repeat (60) @(posedge clk);
         check_run(1'(i % 2));
      end
      // Continuous: re-arms by itself until a readout while stopped
      trigVal <= 16'h0018;
      arm(1'b1, ttc_pkg::COND_EQ, 16'h0018);
      wait_run(1'b0, 100);
      wait_run(1'b1, 400);
      wait_run(1'b0, 100);
      bus(1'b0, ttc_pkg::OFS_RDDATA, 32'h00000000);
      repeat (600) @(posedge clk);
      check_run(1'b0);
      stop_test();
   end
endmodule : ttc_top_bench
